// file: rtl/rpd_pkg.sv
/*
  Constants, register map and state encoding for the relay pulse/delay output sequencer.
  Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register port.
*/
// Functional notes
// - manual mode: output follows software level only
// - pulse mode: alternate active/inactive after start
// - delayed assert: hold inactive for delay, then active
// - delayed release: go inactive after delay elapses
// - mode resets to manual
// - pulse style matters only in pulse mode
// - continuous style repeats forever; reset default
// - counted style: exactly programmed pulses, then stop
// - pulse is active plus inactive; count resets 1
// - inactive width in 100 ms, 1-9999, reset 1
package rpd_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL           = 8'h00;
  localparam logic [7:0] ADDR_MANUAL         = 8'h04;
  localparam logic [7:0] ADDR_CMD            = 8'h08;
  localparam logic [7:0] ADDR_PULSE_COUNT    = 8'h0C;
  localparam logic [7:0] ADDR_INACTIVE_WIDTH = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE_WIDTH   = 8'h14;
  localparam logic [7:0] ADDR_DELAY          = 8'h18;
  localparam logic [7:0] ADDR_STATUS         = 8'h1C;
  localparam logic [7:0] ADDR_REMAIN         = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB     = 0;
  localparam int CTRL_STYLE_BIT    = 2;
  localparam int MANUAL_LEVEL_BIT  = 0;
  localparam int CMD_START_BIT     = 0;
  localparam int CMD_STOP_BIT      = 1;
  localparam int STAT_OUT_BIT      = 0;
  localparam int STAT_BUSY_BIT     = 1;
  localparam int REMAIN_PULSE_LSB  = 16;

  // ---------------------------------------------------------------
  // encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_MANUAL          = 2'h0;
  localparam logic [1:0]  MODE_PULSE           = 2'h1;
  localparam logic [1:0]  MODE_DELAYED_ASSERT  = 2'h2;
  localparam logic [1:0]  MODE_DELAYED_RELEASE = 2'h3;
  localparam logic        STYLE_CONTINUOUS     = 1'b0;
  localparam logic        STYLE_COUNTED        = 1'b1;
  localparam logic [1:0]  MODE_RESET           = MODE_MANUAL;
  localparam logic        STYLE_RESET          = STYLE_CONTINUOUS;
  localparam logic [15:0] PULSE_COUNT_RESET    = 16'h0001;
  localparam logic [15:0] WIDTH_RESET          = 16'h0001;
  localparam logic [15:0] DELAY_RESET          = 16'h0001;
  localparam logic [15:0] WIDTH_MIN            = 16'h0001;
  localparam logic [15:0] WIDTH_MAX            = 16'h270F;
  localparam logic [15:0] COUNT_MAX            = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_SLVERR          = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TICK_MS     = 100;
  localparam int CLK_NS      = 10;
  localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_NS;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_DELAY    = 5'h02,
    ST_ACTIVE   = 5'h04,
    ST_INACTIVE = 5'h08,
    ST_HOLD     = 5'h10
  } rpd_state_t;

endpackage : rpd_pkg

// file: rtl/rpd_tick_if.sv
/*
  Tick carrier between the sequencer and its time base.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/100ps
interface rpd_tick_if;
  logic restart;
  logic tick;
  modport gen  (input restart, output tick);
  modport user (output restart, input tick);
endinterface : rpd_tick_if

// file: rtl/rpd_tick_gen.sv
/*
  100 ms time base: one-cycle tick every TICK_CYCLES clocks, restartable.
  Assumes synchronous active-high reset on the single system clock.
*/
`timescale 1ns/100ps
module rpd_tick_gen #(
  parameter int TICK_CYCLES = rpd_pkg::TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  rpd_tick_if.gen   tb
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          tick_reg;
  logic          tick_next;

  // restart realigns the phase so an interval starts a full tick from the command
  always_comb begin
    count_next = count_reg + CW'(1);
    tick_next  = 1'b0;
    if (tb.restart) begin
      count_next = '0;
    end else if (count_reg == LAST) begin
      count_next = '0;
      tick_next  = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign tb.tick = tick_reg;

endmodule : rpd_tick_gen

// file: rtl/rpd_top.sv
/*
  Relay output sequencer: manual, pulse train and two delayed modes, with an AXI4-Lite register port.
  Assumes one 100 MHz clock, synchronous active-high reset, and a master keeping AXI4-Lite rules.
*/
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module rpd_top #(
  parameter int TICK_CYCLES = rpd_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             relay_out
);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : merge_bytes

  // out-of-range settings are pulled into range rather than refused
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] maxv);
    logic [15:0] r;
    r = v;
    if (v < rpd_pkg::WIDTH_MIN) r = rpd_pkg::WIDTH_MIN;
    else if (v > maxv)          r = maxv;
    return r;
  endfunction : clamp

  // ---------------------------------------------------------------
  // bus and configuration state
  // ---------------------------------------------------------------
  logic        aw_full_reg, aw_full_next;
  logic [7:0]  awaddr_reg,  awaddr_next;
  logic        w_full_reg,  w_full_next;
  logic [31:0] wdata_reg,   wdata_next;
  logic [3:0]  wstrb_reg,   wstrb_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  logic [1:0]  mode_reg,    mode_next;
  logic        style_reg,   style_next;
  logic        manual_reg,  manual_next;
  logic [15:0] count_reg,   count_next;
  logic [15:0] inact_reg,   inact_next;
  logic [15:0] act_reg,     act_next;
  logic [15:0] delay_reg,   delay_next;

  // sequencer state
  rpd_pkg::rpd_state_t state_reg, state_next;
  logic        out_reg,     out_next;
  logic [15:0] ticks_reg,   ticks_next;
  logic [15:0] pulses_reg,  pulses_next;

  logic        wr_fire;
  logic [31:0] wr_word;
  logic        start_cmd;
  logic        stop_cmd;
  logic        ctrl_wr;

  rpd_tick_if tick_bus ();

  rpd_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .reset (reset),
    .tb    (tick_bus.gen)
  );

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // a write commits only once its response slot is free
  assign wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_word   = merge_bytes(32'h0000_0000, wdata_reg, wstrb_reg);
  assign start_cmd = wr_fire && (awaddr_reg == rpd_pkg::ADDR_CMD) && wr_word[rpd_pkg::CMD_START_BIT];
  assign stop_cmd  = wr_fire && (awaddr_reg == rpd_pkg::ADDR_CMD) && wr_word[rpd_pkg::CMD_STOP_BIT];
  assign ctrl_wr   = wr_fire && (awaddr_reg == rpd_pkg::ADDR_CTRL);
  // interval timing counts whole ticks from the start command
  assign tick_bus.restart = start_cmd && (state_reg == rpd_pkg::ST_IDLE)
                            && (mode_reg != rpd_pkg::MODE_MANUAL);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] old_v;
    logic [31:0] new_v;
    old_v        = 32'h0000_0000;
    new_v        = 32'h0000_0000;
    aw_full_next = aw_full_reg;
    awaddr_next  = awaddr_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    mode_next    = mode_reg;
    style_next   = style_reg;
    manual_next  = manual_reg;
    count_next   = count_reg;
    inact_next   = inact_reg;
    act_next     = act_reg;
    delay_next   = delay_reg;

    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;

    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = rpd_pkg::RESP_OKAY;
      case (awaddr_reg)
        rpd_pkg::ADDR_CTRL: begin
          old_v = {29'h0, style_reg, mode_reg};
          new_v = merge_bytes(old_v, wdata_reg, wstrb_reg);
          mode_next  = new_v[rpd_pkg::CTRL_MODE_LSB +: 2];
          style_next = new_v[rpd_pkg::CTRL_STYLE_BIT];
        end
        rpd_pkg::ADDR_MANUAL: begin
          new_v = merge_bytes({31'h0, manual_reg}, wdata_reg, wstrb_reg);
          manual_next = new_v[rpd_pkg::MANUAL_LEVEL_BIT];
        end
        rpd_pkg::ADDR_PULSE_COUNT: begin
          new_v = merge_bytes({16'h0, count_reg}, wdata_reg, wstrb_reg);
          count_next = clamp(new_v[15:0], rpd_pkg::COUNT_MAX);
        end
        rpd_pkg::ADDR_INACTIVE_WIDTH: begin
          new_v = merge_bytes({16'h0, inact_reg}, wdata_reg, wstrb_reg);
          inact_next = clamp(new_v[15:0], rpd_pkg::WIDTH_MAX);
        end
        rpd_pkg::ADDR_ACTIVE_WIDTH: begin
          new_v = merge_bytes({16'h0, act_reg}, wdata_reg, wstrb_reg);
          act_next = clamp(new_v[15:0], rpd_pkg::WIDTH_MAX);
        end
        rpd_pkg::ADDR_DELAY: begin
          new_v = merge_bytes({16'h0, delay_reg}, wdata_reg, wstrb_reg);
          delay_next = clamp(new_v[15:0], rpd_pkg::WIDTH_MAX);
        end
        rpd_pkg::ADDR_CMD, rpd_pkg::ADDR_STATUS, rpd_pkg::ADDR_REMAIN: begin
          bresp_next = rpd_pkg::RESP_OKAY;
        end
        default: begin
          bresp_next = rpd_pkg::RESP_SLVERR;
        end
      endcase
    end

    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = rpd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        rpd_pkg::ADDR_CTRL:           rdata_next = {29'h0, style_reg, mode_reg};
        rpd_pkg::ADDR_MANUAL:         rdata_next = {31'h0, manual_reg};
        rpd_pkg::ADDR_CMD:            rdata_next = 32'h0000_0000;
        rpd_pkg::ADDR_PULSE_COUNT:    rdata_next = {16'h0, count_reg};
        rpd_pkg::ADDR_INACTIVE_WIDTH: rdata_next = {16'h0, inact_reg};
        rpd_pkg::ADDR_ACTIVE_WIDTH:   rdata_next = {16'h0, act_reg};
        rpd_pkg::ADDR_DELAY:          rdata_next = {16'h0, delay_reg};
        rpd_pkg::ADDR_STATUS:         rdata_next = {30'h0, (state_reg != rpd_pkg::ST_IDLE), out_reg};
        rpd_pkg::ADDR_REMAIN:         rdata_next = {pulses_reg, ticks_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = rpd_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_full_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= rpd_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= rpd_pkg::RESP_OKAY;
      mode_reg    <= rpd_pkg::MODE_RESET;
      style_reg   <= rpd_pkg::STYLE_RESET;
      manual_reg  <= 1'b0;
      count_reg   <= rpd_pkg::PULSE_COUNT_RESET;
      inact_reg   <= rpd_pkg::WIDTH_RESET;
      act_reg     <= rpd_pkg::WIDTH_RESET;
      delay_reg   <= rpd_pkg::DELAY_RESET;
    end else begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      mode_reg    <= mode_next;
      style_reg   <= style_next;
      manual_reg  <= manual_next;
      count_reg   <= count_next;
      inact_reg   <= inact_next;
      act_reg     <= act_next;
      delay_reg   <= delay_next;
    end
  end

  // ---------------------------------------------------------------
  // output sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic last_tick;
    last_tick   = tick_bus.tick && (ticks_reg == 16'h0001);
    state_next  = state_reg;
    out_next    = out_reg;
    ticks_next  = ticks_reg;
    pulses_next = pulses_reg;
    if (tick_bus.tick && (ticks_reg > 16'h0001)) ticks_next = ticks_reg - 16'h0001;

    case (state_reg)
      rpd_pkg::ST_IDLE: begin
        if (start_cmd) begin
          case (mode_reg)
            rpd_pkg::MODE_PULSE: begin
              state_next  = rpd_pkg::ST_ACTIVE;
              out_next    = 1'b1;
              ticks_next  = act_reg;
              pulses_next = count_reg;
            end
            rpd_pkg::MODE_DELAYED_ASSERT: begin
              state_next = rpd_pkg::ST_DELAY;
              out_next   = 1'b0;
              ticks_next = delay_reg;
            end
            rpd_pkg::MODE_DELAYED_RELEASE: begin
              state_next = rpd_pkg::ST_DELAY;
              out_next   = 1'b1;
              ticks_next = delay_reg;
            end
            default: begin
              state_next = rpd_pkg::ST_IDLE;
            end
          endcase
        end
      end
      rpd_pkg::ST_DELAY: begin
        if (last_tick) begin
          if (mode_reg == rpd_pkg::MODE_DELAYED_ASSERT) begin
            state_next = rpd_pkg::ST_HOLD;
            out_next   = 1'b1;
          end else begin
            state_next = rpd_pkg::ST_IDLE;
            out_next   = 1'b0;
          end
          ticks_next = 16'h0000;
        end
      end
      rpd_pkg::ST_ACTIVE: begin
        if (last_tick) begin
          state_next = rpd_pkg::ST_INACTIVE;
          out_next   = 1'b0;
          ticks_next = inact_reg;
        end
      end
      rpd_pkg::ST_INACTIVE: begin
        // a pulse is complete only at the end of its inactive half
        if (last_tick) begin
          if (style_reg == rpd_pkg::STYLE_COUNTED && pulses_reg <= 16'h0001) begin
            state_next  = rpd_pkg::ST_IDLE;
            ticks_next  = 16'h0000;
            pulses_next = 16'h0000;
          end else begin
            state_next = rpd_pkg::ST_ACTIVE;
            out_next   = 1'b1;
            ticks_next = act_reg;
            if (style_reg == rpd_pkg::STYLE_COUNTED) pulses_next = pulses_reg - 16'h0001;
          end
        end
      end
      rpd_pkg::ST_HOLD: begin
        ticks_next = 16'h0000;
      end
      default: begin
        state_next = rpd_pkg::ST_IDLE;
        out_next   = 1'b0;
      end
    endcase

    // stop or a mode rewrite abandons any timed sequence
    if (stop_cmd || ctrl_wr) begin
      state_next  = rpd_pkg::ST_IDLE;
      out_next    = 1'b0;
      ticks_next  = 16'h0000;
      pulses_next = 16'h0000;
    end
    if (mode_reg == rpd_pkg::MODE_MANUAL) begin
      state_next  = rpd_pkg::ST_IDLE;
      out_next    = manual_reg;
      ticks_next  = 16'h0000;
      pulses_next = 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg  <= rpd_pkg::ST_IDLE;
      out_reg    <= 1'b0;
      ticks_reg  <= 16'h0000;
      pulses_reg <= 16'h0000;
    end else begin
      state_reg  <= state_next;
      out_reg    <= out_next;
      ticks_reg  <= ticks_next;
      pulses_reg <= pulses_next;
    end
  end

  assign relay_out = out_reg;

endmodule : rpd_top

// file: verification/rpd_properties.sv
/*
  Checker for rpd_top: bus handshake and reset behaviour seen at the top ports.
  Assumes it is bound onto rpd_top; one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module rpd_properties #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        relay_out
);
  // ---------------------------------------------------------------
  // read address capture
  // ---------------------------------------------------------------
  logic [7:0] ar_reg;
  logic [7:0] ar_next;
  always_comb begin
    ar_next = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_reg;
  end
  always_ff @(posedge clock) begin
    ar_reg <= ar_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_reset_idle:
    assert property ($fell(reset) |-> !relay_out && !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("r dropped");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_ar_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken while r pending");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  a_bad_read:
    assert property ($rose(s_axi_rvalid) && ar_reg > 8'h20
      |-> s_axi_rresp == rpd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  a_cmd_reads_zero:
    assert property ($rose(s_axi_rvalid) && ar_reg == rpd_pkg::ADDR_CMD |-> s_axi_rdata == 32'h0)
      else $error("cmd read not zero");
  a_good_read:
    assert property ($rose(s_axi_rvalid) && ar_reg <= 8'h20 && ar_reg[1:0] == 2'h0
      |-> s_axi_rresp == rpd_pkg::RESP_OKAY) else $error("mapped read refused");
endmodule : rpd_properties

bind rpd_top rpd_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock(clock), .reset(reset),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .relay_out(relay_out));

// file: verification/rpd_relay_load.sv
/*
  Relay load model: counts closures and run lengths seen on the relay drive.
  Assumes relay_out is a registered level on clock.
*/
`timescale 1ns/100ps
module rpd_relay_load (
  input  wire logic   clock,
  input  wire logic   reset,
  input  wire logic   clear,
  input  wire logic   relay_out,
  output logic [31:0] rise_count,
  output logic [31:0] high_len,
  output logic [31:0] low_len
);
  logic        prev;
  logic [31:0] run;
  // ---------------------------------------------------------------
  // run-length monitor
  // ---------------------------------------------------------------
  // clear re-arms on the present level so a standing closure is not counted
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      prev       <= relay_out;
      run        <= 32'h1;
      rise_count <= 32'h0;
    end else if (relay_out !== prev) begin
      prev <= relay_out;
      run  <= 32'h1;
      if (prev) high_len <= run;
      else low_len <= run;
      if (relay_out) rise_count <= rise_count + 32'h1;
    end else begin
      run <= run + 32'h1;
    end
  end
endmodule : rpd_relay_load

// file: verification/tb.sv
/*
  Self-checking bench for rpd_top with a relay load on its output.
  Assumes the tick divider is shortened to TCK clocks per 100 ms tick.
*/
`timescale 1ns/100ps
module tb;
  localparam int TCK = 10;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, load_clear = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, relay_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rise_count, high_len, low_len, rd;
  int          num_errors = 0;
  int          n_tests = 0;

  rpd_top #(.TICK_CYCLES(TCK)) dut_u (.*);
  rpd_relay_load load_u (.clock(clock), .reset(reset), .clear(load_clear), .relay_out(relay_out),
    .rise_count(rise_count), .high_len(high_len), .low_len(low_len));

  initial begin
    forever #5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timed_out();
    check(32'h0, 32'h1);
    report_and_stop();
  endtask : timed_out

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        done = 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
    if (!done) timed_out();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
        done = 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
    if (!done) timed_out();
  endtask : axi_read

  task automatic clear_load();
    @(posedge clock);
    load_clear <= 1'b1;
    @(posedge clock);
    load_clear <= 1'b0;
  endtask : clear_load
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0]  addr [6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h08};
    logic [31:0] exp [6] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0};
    for (int i = 0; i < 6; i++) begin
      axi_read(addr[i]);
      check(rd, exp[i]);
    end
    axi_read(8'h40);
    check(32'(resp), 32'(rpd_pkg::RESP_SLVERR));
    axi_write(8'h40, 32'h1);
    check(32'(resp), 32'(rpd_pkg::RESP_SLVERR));
  endtask : t_reset_values

  task automatic t_manual();
    axi_write(rpd_pkg::ADDR_MANUAL, 32'h1);
    repeat (2) @(posedge clock);
    check(32'(relay_out), 32'h1);
    clear_load();
    axi_write(rpd_pkg::ADDR_CMD, 32'h1);
    repeat (60) @(posedge clock);
    check(rise_count, 32'h0);
    check(32'(relay_out), 32'h1);
    axi_write(rpd_pkg::ADDR_MANUAL, 32'h0);
    repeat (2) @(posedge clock);
    check(32'(relay_out), 32'h0);
  endtask : t_manual

  task automatic t_counted();
    axi_write(rpd_pkg::ADDR_INACTIVE_WIDTH, 32'h0);
    axi_read(rpd_pkg::ADDR_INACTIVE_WIDTH);
    check(rd, 32'h1);
    axi_write(rpd_pkg::ADDR_ACTIVE_WIDTH, 32'h2710);
    axi_read(rpd_pkg::ADDR_ACTIVE_WIDTH);
    check(rd, 32'h270F);
    axi_write(rpd_pkg::ADDR_CTRL, 32'h5);
    axi_write(rpd_pkg::ADDR_PULSE_COUNT, 32'h3);
    axi_write(rpd_pkg::ADDR_ACTIVE_WIDTH, 32'h2);
    axi_write(rpd_pkg::ADDR_INACTIVE_WIDTH, 32'h3);
    clear_load();
    axi_write(rpd_pkg::ADDR_CMD, 32'h1);
    repeat (220) @(posedge clock);
    check(rise_count, 32'h3);
    check(high_len, 32'(2 * TCK));
    check(low_len, 32'(3 * TCK));
    axi_read(rpd_pkg::ADDR_STATUS);
    check(rd, 32'h0);
  endtask : t_counted

  task automatic t_continuous();
    axi_write(rpd_pkg::ADDR_CTRL, 32'h1);
    clear_load();
    axi_write(rpd_pkg::ADDR_CMD, 32'h1);
    repeat (400) @(posedge clock);
    check(32'(rise_count > 32'h5), 32'h1);
    axi_write(rpd_pkg::ADDR_CMD, 32'h2);
    repeat (2) @(posedge clock);
    check(32'(relay_out), 32'h0);
  endtask : t_continuous

  // counted style is set on purpose: it must not cut the delayed modes short
  task automatic t_delayed();
    for (int m = 2; m < 4; m++) begin
      axi_write(rpd_pkg::ADDR_CTRL, 32'(m + 4));
      axi_write(rpd_pkg::ADDR_DELAY, 32'h3);
      clear_load();
      axi_write(rpd_pkg::ADDR_CMD, 32'h1);
      repeat (20) @(posedge clock);
      check(32'(relay_out), 32'(m == 3));
      repeat (20) @(posedge clock);
      check(32'(relay_out), 32'(m == 2));
      check(rise_count, 32'h1);
      axi_read(rpd_pkg::ADDR_STATUS);
      check(rd, 32'(m == 2) * 32'h3);
      axi_write(rpd_pkg::ADDR_CTRL, 32'h0);
    end
  endtask : t_delayed

  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset_values();
    t_manual();
    t_counted();
    t_continuous();
    t_delayed();
    report_and_stop();
  end
endmodule : tb
